// >>> phy_link_model.sv
// Physical layer stand-in that feeds received primitives to the sequencer
`timescale 1ns/10ps
`default_nettype none
module phy_link_model
   import tx_tail_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire tx_word_type tx_word,
   input  wire prim_type    send_kind,
   input  wire logic        send_err,
   input  wire logic        link_up,
   input  wire prim_type    reply_kind,
   input  wire logic        reply_en,
   input  wire logic [3:0]  reply_dly,
   output var  rx_word_type rx_word,
   output var  logic        phy_ready
);
   logic [3:0] wtrm_cnt_r;
   // Counts cycles of end-of-frame wait seen on the line
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wtrm_cnt_r <= 4'h0;
      else if (tx_word.kind == prim_wtrm)
         wtrm_cnt_r <= wtrm_cnt_r + 4'h1;
      else
         wtrm_cnt_r <= 4'h0;
   end
   // Status reply after the chosen delay, else the commanded dword
   always_comb
   begin
      phy_ready = link_up;
      if (reply_en && tx_word.kind == prim_wtrm && wtrm_cnt_r >= reply_dly)
         rx_word = '{kind: reply_kind, decode_err: 1'b0};
      else
         rx_word = '{kind: send_kind, decode_err: send_err};
   end
endmodule : phy_link_model
`default_nettype wire

// >>> test_tx_tail_seq.sv
// Self-checking testbench for the transmit frame tail sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tx_tail_consts.svh"
module test_tx_tail_seq
   import tx_tail_pkg::*;
;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         tp_start = 1'b0;
   logic         tp_data_valid = 1'b0;
   logic [31:0]  tp_data = 32'h0;
   logic         tp_done = 1'b0;
   logic         tp_escape = 1'b0;
   prim_type     send_kind = prim_other;
   logic         send_err = 1'b0;
   logic         link_up = 1'b1;
   prim_type     reply_kind = prim_r_ok;
   logic         reply_en = 1'b0;
   logic [3:0]   reply_dly = 4'h0;
   rx_word_type  rx_word;
   logic         phy_ready;
   logic         tp_ready_r;
   tx_word_type  tx_word_r;
   logic         note_valid_r;
   note_type     note_code_r;
   tx_state_type state_r;
   int           n_fail = 0;
   int           checks_done = 0;

   always #25 clk = ~clk;

   tx_tail_seq #(.DW(32)) dut_u (.clk(clk), .rst_n(rst_n), .phy_ready(phy_ready),
      .rx_word(rx_word), .tp_start(tp_start), .tp_data_valid(tp_data_valid),
      .tp_data(tp_data), .tp_done(tp_done), .tp_escape(tp_escape),
      .tp_ready_r(tp_ready_r), .tx_word_r(tx_word_r), .note_valid_r(note_valid_r),
      .note_code_r(note_code_r), .state_r(state_r));

   phy_link_model phy_u (.clk(clk), .rst_n(rst_n), .tx_word(tx_word_r),
      .send_kind(send_kind), .send_err(send_err), .link_up(link_up),
      .reply_kind(reply_kind), .reply_en(reply_en), .reply_dly(reply_dly),
      .rx_word(rx_word), .phy_ready(phy_ready));

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic step();
      @(posedge clk);
      @(negedge clk);
   endtask : step

   task automatic chk_st(input tx_state_type s);
      chk(36'(state_r), 36'(s));
   endtask : chk_st

   task automatic chk_note(input note_type c);
      chk(36'(note_valid_r), 36'h1);
      chk(36'(note_code_r), 36'(c));
      step();
      chk(36'(note_valid_r), 36'h0);
   endtask : chk_note

   function automatic logic [31:0] crc_of(input logic [31:0] d);
      logic [31:0] c;
      c = `TX_CRC_INIT;
      for (int i = 31; i >= 0; i--)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `TX_CRC_POLY : 32'h0);
      return c;
   endfunction : crc_of

   task automatic start_frame();
      tp_start = 1'b1;
      step();
      tp_start = 1'b0;
      chk_st(payload_emit_state);
      chk(36'(tp_ready_r), 36'h1);
   endtask : start_frame

   task automatic s_frame(input prim_type rep, input note_type c, input logic [3:0] dly);
      start_frame();
      tp_data = 32'h1234abcd;
      tp_data_valid = 1'b1;
      tp_done = 1'b1;
      reply_kind = rep;
      reply_dly = dly;
      reply_en = 1'b1;
      step();
      tp_data_valid = 1'b0;
      tp_done = 1'b0;
      chk_st(checksum_emit_state);
      chk(tx_word_r, {prim_data, tp_data});
      step();
      chk(tx_word_r, {prim_data, crc_of(tp_data)});
      chk_st(frame_end_emit_state);
      step();
      chk(tx_word_r, {prim_eof, 32'h0});
      chk_st(wait_end_state);
      for (int i = 0; i <= dly; i++)
      begin
         step();
         chk(tx_word_r, {prim_wtrm, 32'h0});
         chk_st(wait_end_state);
      end
      step();
      chk_st(idle_state);
      chk_note(c);
      reply_en = 1'b0;
   endtask : s_frame

   task automatic s_holds();
      start_frame();
      step();
      chk_st(local_hold_state);
      step();
      chk(tx_word_r, {prim_hold, 32'h0});
      chk_st(local_hold_state);
      tp_data_valid = 1'b1;
      send_kind = prim_hold;
      step();
      chk_st(peer_hold_ack_state);
      step();
      chk_st(peer_hold_ack_state);
      chk(tx_word_r, {prim_holda, 32'h0});
      send_kind = prim_other;
      send_err = 1'b1;
      step();
      chk_st(peer_hold_ack_state);
      send_err = 1'b0;
      step();
      chk_st(payload_emit_state);
      tp_data_valid = 1'b0;
      step();
      chk_st(local_hold_state);
      tp_data_valid = 1'b1;
      step();
      chk_st(payload_emit_state);
      tp_data_valid = 1'b0;
      step();
      tp_done = 1'b1;
      step();
      tp_done = 1'b0;
      chk_st(checksum_emit_state);
      send_kind = prim_sync;
      step();
      chk_st(idle_state);
      chk_note(note_illegal);
      send_kind = prim_other;
   endtask : s_holds

   task automatic s_dmat_lost();
      start_frame();
      step();
      tp_data_valid = 1'b1;
      send_kind = prim_hold;
      step();
      send_kind = prim_dmat;
      step();
      send_kind = prim_other;
      tp_data_valid = 1'b0;
      chk_st(checksum_emit_state);
      chk_note(note_term);
      link_up = 1'b0;
      step();
      chk_st(comm_lost_state);
      link_up = 1'b1;
      chk_note(note_lost);
      start_frame();
      tp_data_valid = 1'b1;
      send_kind = prim_dmat;
      step();
      tp_data_valid = 1'b0;
      send_kind = prim_other;
      chk_st(checksum_emit_state);
      chk_note(note_term);
      send_kind = prim_sync;
      step();
      send_kind = prim_other;
      chk_st(idle_state);
      chk_note(note_illegal);
   endtask : s_dmat_lost

   task automatic s_escape(input int hold_first);
      start_frame();
      if (hold_first != 0)
         step();
      tp_escape = 1'b1;
      step();
      tp_escape = 1'b0;
      chk_st(frame_abort_state);
      send_kind = prim_sync;
      step();
      send_kind = prim_other;
      chk_st(idle_state);
   endtask : s_escape

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   initial
   begin
      #(3000 * 50);
      n_fail++;
      give_verdict();
   end

   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk(tx_word_r, {prim_sync, 32'h0});
      chk_st(idle_state);
      s_frame(prim_r_ok, note_good, 4'h0);
      s_frame(prim_r_err, note_bad, 4'h2);
      s_frame(prim_sync, note_sync, 4'h1);
      s_holds();
      s_dmat_lost();
      s_escape(0);
      s_escape(1);
      give_verdict();
   end
endmodule : test_tx_tail_seq
`default_nettype wire

// >>> tx_tail_consts.svh
// Constants for the transmit frame tail sequencer
`ifndef TX_TAIL_CONSTS_SVH
`define TX_TAIL_CONSTS_SVH
`define TX_DWORD_W   32
`define TX_CRC_POLY  32'h04c11db7
`define TX_CRC_INIT  32'hffffffff
`define TX_CRC_CYC   1
`define TX_EOF_CYC   1
`endif

// >>> tx_tail_pkg.sv
// Types for the transmit frame tail sequencer
package tx_tail_pkg;
   typedef enum logic [3:0] {
      prim_data  = 4'h0,
      prim_hold  = 4'h1,
      prim_holda = 4'h2,
      prim_dmat  = 4'h3,
      prim_sync  = 4'h4,
      prim_r_ok  = 4'h5,
      prim_r_err = 4'h6,
      prim_eof   = 4'h7,
      prim_wtrm  = 4'h8,
      prim_other = 4'h9
   } prim_type;

   typedef enum logic [8:0] {
      idle_state           = 9'h001,
      payload_emit_state   = 9'h002,
      peer_hold_ack_state  = 9'h004,
      local_hold_state     = 9'h008,
      checksum_emit_state  = 9'h010,
      frame_end_emit_state = 9'h020,
      wait_end_state       = 9'h040,
      comm_lost_state      = 9'h080,
      frame_abort_state    = 9'h100
   } tx_state_type;

   typedef enum logic [2:0] {
      note_good    = 3'h0,
      note_bad     = 3'h1,
      note_sync    = 3'h2,
      note_illegal = 3'h3,
      note_term    = 3'h4,
      note_lost    = 3'h5
   } note_type;

   typedef struct packed {
      prim_type kind;
      logic     decode_err;
   } rx_word_type;

   typedef struct packed {
      prim_type    kind;
      logic [31:0] data;
   } tx_word_type;
endpackage : tx_tail_pkg

// >>> tx_tail_seq.sv
// Link transmit frame tail sequencer: holds, CRC, EOF and end-of-frame status
// Notes on behaviour
// (RULE1) Receiver hold sends HOLDA, resumes on data
// (RULE2) Receiver hold stays on HOLD or decode error
// (RULE3) DMAT in hold: notify, terminate, go CRC
// (RULE4) Escape request from transport aborts the frame
// (RULE5) SYNC in hold/CRC/EOF: idle, illegal error
// (RULE6) Phy not ready: notify, comm lost state
// (RULE7) No data, no HOLD received: send HOLD
// (RULE8) Send hold resumes data when data returns
// (RULE9) HOLD received with data ready: receiver hold
// (RULE10) Send hold persists without data, without SYNC
// (RULE11) All data done in send hold: CRC
// (RULE12) Send frame CRC, then go to EOF
// (RULE13) Send EOF, then wait sending WTRM
// (RULE14) R_OK, R_ERR or SYNC: report, go idle
// (RULE15) Wait keeps sending WTRM on other dwords
// (RULE16) Each data dword feeds the CRC first
// (RULE17) DMAT while sending data, tp_done low: notify, terminate, go CRC
// (RULE18) Notifications are one-cycle pulses with code
`timescale 1ns/10ps
`default_nettype none
`include "tx_tail_consts.svh"

module tx_tail_seq
   import tx_tail_pkg::*;
#(
   parameter int DW = `TX_DWORD_W
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        phy_ready,
   input  wire rx_word_type rx_word,
   input  wire logic        tp_start,
   input  wire logic        tp_data_valid,
   input  wire logic [DW-1:0] tp_data,
   input  wire logic        tp_done,
   input  wire logic        tp_escape,
   output var  logic        tp_ready_r,
   output var  tx_word_type tx_word_r,
   output var  logic        note_valid_r,
   output var  note_type    note_code_r,
   output var  tx_state_type state_r
);

   if (DW != 32)
   begin : g_dw_check
      $error("tx_tail_seq serves 32-bit dwords only");
   end

   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] d);
      logic [31:0] c;
      c = crc;
      for (int i = 31; i >= 0; i--)
      begin
         if (c[31] ^ d[i])
         begin
            c = {c[30:0], 1'b0} ^ `TX_CRC_POLY;
         end
         else
         begin
            c = {c[30:0], 1'b0};
         end
      end
      return c;
   endfunction : crc_step

   tx_state_type state_nxt;
   tx_word_type  tx_nxt;
   logic [31:0]  crc_r;
   logic [31:0]  crc_nxt;
   logic         note_nxt;
   note_type     code_nxt;
   logic         take;
   logic         rx_hold;
   logic         rx_sync;
   logic         rx_dmat;

   assign rx_hold = (rx_word.kind == prim_hold);
   assign rx_sync = (rx_word.kind == prim_sync);
   assign rx_dmat = (rx_word.kind == prim_dmat);
   assign take    = tp_ready_r && tp_data_valid;

   // Next state and notifications
   always_comb
   begin
      state_nxt = state_r;
      note_nxt  = 1'b0;
      code_nxt  = note_code_r;
      unique case (state_r)
         idle_state:
            if (tp_start && phy_ready)
               state_nxt = payload_emit_state;
         comm_lost_state:
            if (phy_ready)
               state_nxt = idle_state;
         frame_abort_state:
            if (!phy_ready)
            begin
               state_nxt = comm_lost_state;
               note_nxt  = 1'b1;
               code_nxt  = note_lost;
            end
            else if (rx_sync)
               state_nxt = idle_state;
         default:
         begin
            if (!phy_ready)
            begin
               state_nxt = comm_lost_state;  // [RULE6]
               note_nxt  = 1'b1;
               code_nxt  = note_lost;        // [RULE18]
            end
            else if (tp_escape && (state_r == payload_emit_state
                     || state_r == peer_hold_ack_state || state_r == local_hold_state))
               state_nxt = frame_abort_state;  // [RULE4]
            else if (state_r == wait_end_state)
            begin
               if (rx_word.kind inside {prim_r_ok, prim_r_err, prim_sync})
               begin
                  state_nxt = idle_state;  // [RULE14]
                  note_nxt  = 1'b1;
                  code_nxt  = rx_sync ? note_sync
                            : (rx_word.kind == prim_r_ok) ? note_good : note_bad;
               end
               else
                  state_nxt = wait_end_state;  // [RULE15]
            end
            else if (state_r == peer_hold_ack_state && rx_word.decode_err)
               state_nxt = peer_hold_ack_state;  // [RULE2]
            else if (rx_sync)
            begin
               state_nxt = idle_state;  // [RULE5]
               note_nxt  = 1'b1;
               code_nxt  = note_illegal;
            end
            else if (state_r == checksum_emit_state)
               state_nxt = frame_end_emit_state;  // [RULE12]
            else if (state_r == frame_end_emit_state)
               state_nxt = wait_end_state;  // [RULE13]
            else if (rx_dmat && state_r != payload_emit_state)
            begin
               state_nxt = checksum_emit_state;  // [RULE3]
               note_nxt  = 1'b1;
               code_nxt  = note_term;
            end
            else if (state_r == peer_hold_ack_state)
            begin
               if (!rx_hold && tp_data_valid)
                  state_nxt = payload_emit_state;  // [RULE1]
            end
            else if (tp_done)
               state_nxt = checksum_emit_state;  // [RULE11]
            else if (state_r == payload_emit_state)
            begin
               if (rx_hold)
                  state_nxt = peer_hold_ack_state;
               else if (rx_dmat)
               begin
                  state_nxt = checksum_emit_state;  // [RULE17]
                  note_nxt  = 1'b1;
                  code_nxt  = note_term;
               end
               else if (!tp_data_valid)
                  state_nxt = local_hold_state;  // [RULE7]
            end
            else if (tp_data_valid)
               state_nxt = rx_hold ? peer_hold_ack_state  // [RULE9]
                                   : payload_emit_state;  // [RULE8]
            else
               state_nxt = local_hold_state;  // [RULE10]
         end
      endcase
   end

   // Transmit word and CRC
   always_comb
   begin
      tx_nxt.kind = prim_sync;
      tx_nxt.data = '0;
      crc_nxt     = crc_r;
      if (state_r == idle_state)
         crc_nxt = `TX_CRC_INIT;
      else if (take)
         crc_nxt = crc_step(crc_r, tp_data);  // [RULE16]
      unique case (state_r)
         payload_emit_state:
            if (take)
               tx_nxt = '{kind: prim_data, data: tp_data};
            else
               tx_nxt.kind = prim_hold;
         peer_hold_ack_state:  tx_nxt.kind = prim_holda;  // [RULE1]
         local_hold_state:     tx_nxt.kind = prim_hold;   // [RULE7]
         checksum_emit_state:  tx_nxt = '{kind: prim_data, data: crc_r};  // [RULE12]
         frame_end_emit_state: tx_nxt.kind = prim_eof;    // [RULE13]
         wait_end_state:       tx_nxt.kind = prim_wtrm;   // [RULE15]
         idle_state,
         comm_lost_state,
         frame_abort_state:    tx_nxt.kind = prim_sync;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r      <= idle_state;
         crc_r        <= `TX_CRC_INIT;
         tx_word_r    <= '{kind: prim_sync, data: 32'h0000_0000};
         tp_ready_r   <= 1'b0;
         note_valid_r <= 1'b0;
         note_code_r  <= note_good;
      end
      else
      begin
         state_r      <= state_nxt;
         crc_r        <= crc_nxt;
         tx_word_r    <= tx_nxt;
         tp_ready_r   <= (state_nxt == payload_emit_state);
         note_valid_r <= note_nxt;  // [RULE18]
         note_code_r  <= code_nxt;
      end
   end

   logic live;
   assign live = phy_ready && !tp_escape;

   property p_holda;
      @(posedge clk) disable iff (!rst_n)
      state_r == peer_hold_ack_state |=> tx_word_r.kind == prim_holda;
   endproperty
   a_holda: assert property (p_holda) else $error("HOLDA not sent in receiver hold"); // [RULE1]

   property p_peer_stay;
      @(posedge clk) disable iff (!rst_n)
      state_r == peer_hold_ack_state && live && (rx_hold || rx_word.decode_err)
      |=> state_r == peer_hold_ack_state;
   endproperty
   a_peer_stay: assert property (p_peer_stay) else $error("Receiver hold left early"); // [RULE2]

   property p_dmat;
      @(posedge clk) disable iff (!rst_n)
      (state_r == local_hold_state
       || (state_r == peer_hold_ack_state && !rx_word.decode_err)) && live && rx_dmat
      |=> state_r == checksum_emit_state && note_valid_r && note_code_r == note_term;
   endproperty
   a_dmat: assert property (p_dmat) else $error("DMAT in hold not handled"); // [RULE3]

   property p_escape;
      @(posedge clk) disable iff (!rst_n)
      phy_ready && tp_escape && (state_r == payload_emit_state
         || state_r == local_hold_state || state_r == peer_hold_ack_state)
      |=> state_r == frame_abort_state ##1 tx_word_r.kind == prim_sync;
   endproperty
   a_escape: assert property (p_escape) else $error("Escape not taken"); // [RULE4]

   property p_sync;
      @(posedge clk) disable iff (!rst_n)
      phy_ready && rx_sync && !rx_word.decode_err && ((!tp_escape
         && (state_r == local_hold_state || state_r == peer_hold_ack_state))
         || state_r == checksum_emit_state || state_r == frame_end_emit_state)
      |=> state_r == idle_state && note_valid_r && note_code_r == note_illegal;
   endproperty
   a_sync: assert property (p_sync) else $error("SYNC not reported as illegal"); // [RULE5]

   property p_lost;
      @(posedge clk) disable iff (!rst_n)
      !phy_ready && !(state_r inside {idle_state, comm_lost_state})
      |=> state_r == comm_lost_state && note_valid_r && note_code_r == note_lost;
   endproperty
   a_lost: assert property (p_lost) else $error("Phy loss not handled"); // [RULE6]

   property p_send_hold;
      @(posedge clk) disable iff (!rst_n)
      state_r == payload_emit_state && live && !tp_done && !tp_data_valid
      && rx_word.kind inside {prim_data, prim_other, prim_r_ok}
      |=> state_r == local_hold_state ##1 tx_word_r.kind == prim_hold;
   endproperty
   a_send_hold: assert property (p_send_hold) else $error("Send hold not entered"); // [RULE7]

   property p_resume;
      @(posedge clk) disable iff (!rst_n)
      state_r == local_hold_state && live && !tp_done && tp_data_valid
      && rx_word.kind inside {prim_data, prim_other, prim_holda}
      |=> state_r == payload_emit_state && tp_ready_r;
   endproperty
   a_resume: assert property (p_resume) else $error("Send hold did not resume"); // [RULE8]

   property p_to_peer;
      @(posedge clk) disable iff (!rst_n)
      state_r == local_hold_state && live && !tp_done && tp_data_valid && rx_hold
      |=> state_r == peer_hold_ack_state ##1 tx_word_r.kind == prim_holda;
   endproperty
   a_to_peer: assert property (p_to_peer) else $error("HOLD not acknowledged"); // [RULE9]

   property p_crc_out;
      @(posedge clk) disable iff (!rst_n)
      state_r == checksum_emit_state && phy_ready && !rx_sync
      |=> state_r == frame_end_emit_state && tx_word_r.kind == prim_data
          && tx_word_r.data == $past(crc_r) ##1 tx_word_r.kind == prim_eof;
   endproperty
   a_crc_out: assert property (p_crc_out) else $error("CRC not followed by EOF"); // [RULE12]

   property p_eof_out;
      @(posedge clk) disable iff (!rst_n)
      state_r == frame_end_emit_state && phy_ready && !rx_sync
      |=> state_r == wait_end_state ##1 tx_word_r.kind == prim_wtrm;
   endproperty
   a_eof_out: assert property (p_eof_out) else $error("EOF not followed by wait"); // [RULE13]

   property p_good;
      @(posedge clk) disable iff (!rst_n)
      state_r == wait_end_state && phy_ready && rx_word.kind == prim_r_ok
      |=> state_r == idle_state && note_valid_r && note_code_r == note_good;
   endproperty
   a_good: assert property (p_good) else $error("Good status not reported"); // [RULE14]

   property p_crc_feed;
      @(posedge clk) disable iff (!rst_n)
      take && state_r == payload_emit_state
      |=> crc_r == crc_step($past(crc_r), $past(tp_data)) && tx_word_r.data == $past(tp_data);
   endproperty
   a_crc_feed: assert property (p_crc_feed) else $error("Dword not fed to CRC"); // [RULE16]

endmodule : tx_tail_seq

`default_nettype wire
